/* File: core/qpm_defs.svh */
// Register map, field positions, reset values and timing constants
`ifndef QPM_DEFS_SVH
`define QPM_DEFS_SVH

// Per-channel result block: channel n starts at n * stride
`define CH_STRIDE        8'h08
`define OFS_SHUNT        3'h0
`define OFS_BUS          3'h1
`define OFS_CURRENT      3'h2
`define OFS_POWER        3'h3
`define OFS_ENERGY       3'h4

`define ADDR_PRIMARY     8'h20
`define ADDR_SECONDARY   8'h21
`define ADDR_STATUS      8'h22
`define ADDR_CAL_BASE    8'h28
`define ADDR_ALERT_BASE  8'h30
`define ADDR_LIMIT_BASE  8'h38

// Primary setup fields
`define PRI_RANGE_BIT    0
`define PRI_MODE_LO      1
`define PRI_CHEN_LO      4
`define PRI_RESET        16'h00FE
// Secondary setup fields
`define SEC_CVR_BIT      0
`define SEC_LATCH_BIT    1
`define SEC_RESET        16'h0000

`define CAL_RESET        16'h0000
`define LIMIT_RESET      16'h0000
`define ALERT_RESET      16'h0000

// Alert setup fields
`define AL_TYPE_LO       0
`define AL_CH_LO         3
// Fault-type codes
`define FT_SHUNT_OVER    3'h1
`define FT_SHUNT_UNDER   3'h2
`define FT_BUS_OVER      3'h3
`define FT_BUS_UNDER     3'h4
`define FT_POWER_OVER    3'h5

// Current = shunt * cal >> shift
`define CAL_SHIFT        11
// Power = |current| * bus * K >> S, i.e. |current| * bus / 20000
`define PWR_K            17'h0_D1B8
`define PWR_SHIFT        30

// Energy accumulates power once per second
`define CLK_HZ           25_000_000
`define TICK_S           1
`define TICK_CYC         (`TICK_S * `CLK_HZ)

`endif

/* File: core/pm_pkg.sv */
// Shared types of the power monitor
package pm_pkg;

   typedef struct packed {
      logic        valid;
      logic [1:0]  ch;
      logic [15:0] shunt;
      logic [15:0] bus;
   } adc_s;

   typedef struct packed {
      logic [1:0] ch;
      logic [2:0] ftype;
   } alert_cfg_s;

endpackage : pm_pkg

/* File: core/quad_power_monitor_alert.sv */
// Result, scaling, energy and alert logic of the four-channel power monitor
//
// What this block does
// (R1) Every channel yields shunt, bus, power, energy
// (R2) Alert pin: fault event or conversion ready
// (R3) Reset: 81.92mV range, continuous, all channels
// (R4) Setup registers default on disable or reset
// (R5) Four calibration registers, one per channel
// (R6) Voltage readings and limits ignore calibration
// (R7) Calibration scales current for any chosen step
// (R8) Alert setup type pairs with its limit
// (R9) Alert channel field; 00b is first channel
// (R10) Type 001b shunt over, 011b bus over
// (R11) Shunt limit compared in shunt code units
// (R12) Limits revert on disable or reset
// (R13) Alert slots target channels independently
// (R14) Power step is current step times 32
// (R15) Energy step is current step times 32
// (R16) Shunt and current are two's complement
// (R17) Alert within two conversion rounds
// (R18) Power alerts may take extra calculation time
// (R19) Compare at selected channel's completed conversion
`timescale 1ns/1ns
`include "qpm_defs.svh"

module quad_power_monitor_alert
   import pm_pkg::*;
#(
   parameter int          N_CH     = 4,
   parameter int          N_SLOT   = 4,
   parameter int unsigned TICK_CYC = `TICK_CYC
) (
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   input  wire logic        ce,
   input  wire logic        dev_en,
   input  wire adc_s        adc,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   output logic      [31:0] reg_rdata,
   output logic             range_sel,
   output logic      [2:0]  conv_mode,
   output logic      [3:0]  ch_en,
   output logic             alert_n
);

   localparam int TW = $clog2(TICK_CYC + 1);

   // Channel and slot indices are two bits wide, so four is the ceiling
   if (N_CH < 1 || N_CH > 4 || N_SLOT < 1 || N_SLOT > 4 ||
       TICK_CYC < 2) begin : g_bad_param
      $error("quad_power_monitor_alert: unsupported parameters");
   end

   // Configuration group
   logic [15:0] prim_q, prim_d, sec_q, sec_d;
   logic [15:0] cal_q   [N_CH];
   logic [15:0] cal_d   [N_CH];
   logic [15:0] acfg_q  [N_SLOT];
   logic [15:0] acfg_d  [N_SLOT];
   logic [15:0] limit_q [N_SLOT];
   logic [15:0] limit_d [N_SLOT];

   always_comb begin
      prim_d  = prim_q;
      sec_d   = sec_q;
      cal_d   = cal_q;
      acfg_d  = acfg_q;
      limit_d = limit_q;
      if (!dev_en) begin
         prim_d = `PRI_RESET; // R3 R4
         sec_d  = `SEC_RESET; // R4
         for (int s = 0; s < N_SLOT; s++) begin
            acfg_d[s]  = `ALERT_RESET;
            limit_d[s] = `LIMIT_RESET; // R12
         end
      end else if (reg_wr) begin
         if (reg_addr == `ADDR_PRIMARY)
            prim_d = reg_wdata;
         if (reg_addr == `ADDR_SECONDARY)
            sec_d = reg_wdata;
         for (int c = 0; c < N_CH; c++) begin
            if (reg_addr == `ADDR_CAL_BASE + 8'(c))
               cal_d[c] = reg_wdata; // R5
         end
         for (int s = 0; s < N_SLOT; s++) begin
            if (reg_addr == `ADDR_ALERT_BASE + 8'(s))
               acfg_d[s] = reg_wdata; // R8
            if (reg_addr == `ADDR_LIMIT_BASE + 8'(s))
               limit_d[s] = reg_wdata; // R8
         end
      end
   end

   // Calibration survives disable; only a supply cycle clears it
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         prim_q <= `PRI_RESET; // R3 R4
         sec_q  <= `SEC_RESET;
         for (int c = 0; c < N_CH; c++)
            cal_q[c] <= `CAL_RESET; // R5
         for (int s = 0; s < N_SLOT; s++) begin
            acfg_q[s]  <= `ALERT_RESET;
            limit_q[s] <= `LIMIT_RESET; // R12
         end
      end else if (ce) begin
         prim_q  <= prim_d;
         sec_q   <= sec_d;
         cal_q   <= cal_d;
         acfg_q  <= acfg_d;
         limit_q <= limit_d;
      end
   end

   assign range_sel = prim_q[`PRI_RANGE_BIT]; // R3
   assign conv_mode = prim_q[`PRI_MODE_LO +: 3]; // R3
   assign ch_en     = prim_q[`PRI_CHEN_LO +: 4]; // R3

   // Energy tick
   // One tick is one energy time step; simulation shortens it
   logic [TW-1:0] tick_cnt_q, tick_cnt_d;
   logic          tick;

   always_comb begin
      tick       = (tick_cnt_q == TW'(TICK_CYC - 1));
      tick_cnt_d = tick ? '0 : tick_cnt_q + TW'(1);
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn)
         tick_cnt_q <= '0;
      else if (ce)
         tick_cnt_q <= tick_cnt_d;
   end

   // Sample pipeline
   // Stage 1 stores voltages and current, stage 2 power, then compare
   logic       done1_q, done1_d, done2_q, done2_d;
   logic [1:0] dch1_q, dch1_d, dch2_q, dch2_d;

   always_comb begin
      // Three-bit compare: a two-bit copy of four would wrap to zero
      done1_d = adc.valid && dev_en && ch_en[adc.ch]
                && ({1'b0, adc.ch} < 3'(N_CH));
      dch1_d  = adc.ch;
      done2_d = done1_q;
      dch2_d  = dch1_q;
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         done1_q <= 1'b0;
         dch1_q  <= 2'h0;
         done2_q <= 1'b0;
         dch2_q  <= 2'h0;
      end else if (ce) begin
         done1_q <= done1_d;
         dch1_q  <= dch1_d;
         done2_q <= done2_d;
         dch2_q  <= dch2_d;
      end
   end

   // Per-channel results
   logic [15:0] shunt_q [N_CH];
   logic [15:0] bus_q   [N_CH];
   logic [15:0] cur_q   [N_CH];
   logic [15:0] pwr_q   [N_CH];
   logic [31:0] nrg_q   [N_CH];

   for (genvar c = 0; c < N_CH; c++) begin : g_ch
      logic        [15:0] shunt_d, bus_d, cur_d, pwr_d;
      logic        [31:0] nrg_d;
      logic signed [32:0] prod;
      logic signed [32:0] scaled;
      logic        [15:0] cur_mag;
      logic        [48:0] pprod;
      logic        [18:0] pscaled;
      logic        [32:0] nsum;

      always_comb begin
         shunt_d = shunt_q[c];
         bus_d   = bus_q[c];
         cur_d   = cur_q[c];
         pwr_d   = pwr_q[c];
         nrg_d   = nrg_q[c];
         // Signed shunt code times calibration gives current
         prod    = $signed(adc.shunt) * $signed({1'b0, cal_q[c]}); // R7
         scaled  = prod >>> `CAL_SHIFT;
         // Current magnitude times bus code, scaled to 32 current steps
         cur_mag = cur_q[c][15] ? 16'(-cur_q[c]) : cur_q[c];
         pprod   = 49'(cur_mag) * 49'(bus_q[c]) * 49'(`PWR_K); // R14
         pscaled = 19'(pprod >> `PWR_SHIFT);
         nsum    = {1'b0, nrg_q[c]} + 33'(pwr_q[c]); // R15
         if (done1_d && adc.ch == 2'(c)) begin
            shunt_d = adc.shunt; // R1 R6 R16
            bus_d   = adc.bus; // R1 R6
            // Saturate so the sign bit stays honest on overflow
            if (scaled > 33'sd32767)
               cur_d = 16'h7FFF; // R16
            else if (scaled < -33'sd32768)
               cur_d = 16'h8000; // R16
            else
               cur_d = scaled[15:0]; // R16
         end
         if (done1_q && dch1_q == 2'(c))
            pwr_d = (pscaled > 19'h0_FFFF) ? 16'hFFFF : pscaled[15:0]; // R1
         if (tick && dev_en)
            nrg_d = nsum[32] ? 32'hFFFF_FFFF : nsum[31:0]; // R1 R15
         if (!dev_en)
            nrg_d = '0;
      end

      always_ff @(posedge clk_sys or negedge rstn) begin
         if (!rstn) begin
            shunt_q[c] <= '0;
            bus_q[c]   <= '0;
            cur_q[c]   <= '0;
            pwr_q[c]   <= '0;
            nrg_q[c]   <= '0;
         end else if (ce) begin
            shunt_q[c] <= shunt_d;
            bus_q[c]   <= bus_d;
            cur_q[c]   <= cur_d;
            pwr_q[c]   <= pwr_d;
            nrg_q[c]   <= nrg_d;
         end
      end
   end

   // Alert slots
   // Compare runs two cycles after the sample so power is already updated
   logic [N_SLOT-1:0] hit;

   for (genvar s = 0; s < N_SLOT; s++) begin : g_slot
      alert_cfg_s  cfg;
      logic [15:0] sh, bv, pw, lim;
      always_comb begin
         cfg.ch    = acfg_q[s][`AL_CH_LO +: 2]; // R9 R13
         cfg.ftype = acfg_q[s][`AL_TYPE_LO +: 3]; // R8
         sh        = shunt_q[dch2_q];
         bv        = bus_q[dch2_q];
         pw        = pwr_q[dch2_q];
         lim       = limit_q[s];
         hit[s]    = 1'b0;
         if (done2_q && cfg.ch == dch2_q) begin // R19 R17
            case (cfg.ftype)
               `FT_SHUNT_OVER:  hit[s] = $signed(sh) > $signed(lim); // R10 R11
               `FT_SHUNT_UNDER: hit[s] = $signed(sh) < $signed(lim); // R11
               `FT_BUS_OVER:    hit[s] = bv > lim; // R10
               `FT_BUS_UNDER:   hit[s] = bv < lim;
               `FT_POWER_OVER:  hit[s] = pw > lim; // R18
               default:         hit[s] = 1'b0;
            endcase
         end
      end
   end

   // Status flags and alert pin
   logic [N_SLOT-1:0] trip_q, trip_d, clr_mask;
   logic              cvr_q, cvr_d, alert_d, stat_rd;

   always_comb begin
      stat_rd = reg_rd && reg_addr == `ADDR_STATUS;
      trip_d  = trip_q;
      for (int s = 0; s < N_SLOT; s++) begin
         clr_mask[s] = 1'b0;
         if (done2_q && acfg_q[s][`AL_CH_LO +: 2] == dch2_q)
            clr_mask[s] = !sec_q[`SEC_LATCH_BIT];
      end
      // Transparent slots follow each compare, latched ones wait for read
      trip_d = trip_q & ~clr_mask;
      if (stat_rd)
         trip_d = '0;
      trip_d = trip_d | hit; // R19
      cvr_d  = (cvr_q && !stat_rd) || done2_q;
      if (!dev_en) begin
         trip_d = '0;
         cvr_d  = 1'b0;
      end
      alert_d = sec_q[`SEC_CVR_BIT] ? cvr_d : |trip_d; // R2
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         trip_q  <= '0;
         cvr_q   <= 1'b0;
         alert_n <= 1'b1;
      end else if (ce) begin
         trip_q  <= trip_d;
         cvr_q   <= cvr_d;
         alert_n <= !alert_d; // R2
      end
   end

   // Register read port
   logic [31:0] rdata_d;
   logic [2:0]  ofs;
   logic [4:0]  chi;

   always_comb begin
      ofs     = reg_addr[2:0];
      chi     = reg_addr[7:3];
      rdata_d = reg_rdata;
      if (reg_rd) begin
         rdata_d = '0;
         if (chi < 5'(N_CH)) begin
            case (ofs)
               `OFS_SHUNT:   rdata_d = {16'h0000, shunt_q[chi[1:0]]};
               `OFS_BUS:     rdata_d = {16'h0000, bus_q[chi[1:0]]};
               `OFS_CURRENT: rdata_d = {16'h0000, cur_q[chi[1:0]]};
               `OFS_POWER:   rdata_d = {16'h0000, pwr_q[chi[1:0]]};
               `OFS_ENERGY:  rdata_d = nrg_q[chi[1:0]];
               default:      rdata_d = '0;
            endcase
         end
         if (reg_addr == `ADDR_PRIMARY)
            rdata_d = {16'h0000, prim_q};
         if (reg_addr == `ADDR_SECONDARY)
            rdata_d = {16'h0000, sec_q};
         if (reg_addr == `ADDR_STATUS)
            rdata_d = 32'({trip_q, cvr_q});
         for (int c = 0; c < N_CH; c++) begin
            if (reg_addr == `ADDR_CAL_BASE + 8'(c))
               rdata_d = {16'h0000, cal_q[c]};
         end
         for (int s = 0; s < N_SLOT; s++) begin
            if (reg_addr == `ADDR_ALERT_BASE + 8'(s))
               rdata_d = {16'h0000, acfg_q[s]};
            if (reg_addr == `ADDR_LIMIT_BASE + 8'(s))
               rdata_d = {16'h0000, limit_q[s]};
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn)
         reg_rdata <= '0;
      else if (ce)
         reg_rdata <= rdata_d;
   end

endmodule : quad_power_monitor_alert

/* File: verification/qpm_props.sv */
// Port assertions of the power monitor, bound to its top module
`timescale 1ns/1ns
module qpm_checker
   import pm_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        rstn,
   input wire logic        ce,
   input wire logic        dev_en,
   input wire adc_s        adc,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic [31:0] reg_rdata,
   input wire logic        range_sel,
   input wire logic [2:0]  conv_mode,
   input wire logic [3:0]  ch_en,
   input wire logic        alert_n
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   wire logic pri_wr = reg_wr && ce && dev_en && reg_addr == 8'h20;

   a_disable_setup:
      assert property (!dev_en && ce |=> !range_sel && conv_mode == 3'h7
         && ch_en == 4'hF) else $error("setup not default when disabled");
   a_disable_alert:
      assert property (!dev_en && ce |=> alert_n)
      else $error("alert active while disabled");
   a_primary_write:
      assert property (pri_wr |=> {ch_en, conv_mode, range_sel}
         == $past(reg_wdata[7:0])) else $error("setup pins miss write");
   a_primary_hold:
      assert property (dev_en && ce && !pri_wr
         |=> $stable({ch_en, conv_mode, range_sel}))
      else $error("setup pins moved without write");
   // Alert may only fall as the result of a finished conversion
   a_alert_cause:
      assert property ($fell(alert_n) |-> $past(adc.valid, 3))
      else $error("alert fell without conversion");
   a_rdata_hold:
      assert property (!(reg_rd && ce) |=> $stable(reg_rdata))
      else $error("read data moved without read");
   a_upper_zero:
      assert property (reg_rd && ce && reg_addr[2:0] != 3'h4
         |=> reg_rdata[31:16] == 16'h0) else $error("upper half not zero");
   a_ce_freeze:
      assert property (!ce |=> $stable(alert_n) && $stable(ch_en))
      else $error("state moved while frozen");

   c_alert: cover property ($fell(alert_n));
   c_energy: cover property (reg_rd && reg_addr == 8'h04);
   c_freeze: cover property (!ce);
endmodule : qpm_checker

bind quad_power_monitor_alert qpm_checker chk (.clk_sys, .rstn, .ce,
   .dev_en, .adc, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
   .range_sel, .conv_mode, .ch_en, .alert_n);

/* File: verification/host_model.sv */
// Host controller model driving the register port
`timescale 1ns/1ns
module host_model (
   input  wire logic        clk_sys,
   input  wire logic [31:0] reg_rdata,
   output logic             reg_wr,
   output logic             reg_rd,
   output logic      [7:0]  reg_addr,
   output logic      [15:0] reg_wdata
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
   end

   // Host must rewrite setup and calibration after each reset
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask : wr

   // Idle bus shows inverted values so stale data cannot pass
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      @(posedge clk_sys);
      q = reg_rdata;
   endtask : rd
endmodule : host_model

/* File: verification/testbench.sv */
// Self-checking bench of the power monitor
`timescale 1ns/1ns
module testbench;
   import pm_pkg::*;
   logic        clk_sys = 1'b0;
   logic        rstn = 1'b0;
   logic        ce = 1'b1;
   logic        dev_en = 1'b1;
   adc_s        adc = '0;
   logic        reg_wr;
   logic        reg_rd;
   logic [7:0]  reg_addr;
   logic [15:0] reg_wdata;
   logic [31:0] reg_rdata;
   logic        range_sel;
   logic [2:0]  conv_mode;
   logic [3:0]  ch_en;
   logic        alert_n;
   int          fails = 0;
   int          samples_checked = 0;

   always #20 clk_sys = ~clk_sys;

   quad_power_monitor_alert #(.TICK_CYC(20)) dut (.clk_sys, .rstn, .ce,
      .dev_en, .adc, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
      .range_sel, .conv_mode, .ch_en, .alert_n);
   host_model host (.clk_sys, .reg_rdata, .reg_wr, .reg_rd, .reg_addr,
      .reg_wdata);

   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : complete_run

   task automatic check(input string nm, input logic [31:0] got, exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : check

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      host.rd(a, q);
      check($sformatf("reg %h", a), q, exp);
   endtask : rchk

   task automatic sample(input logic [1:0] c, input logic [15:0] s, b);
      @(posedge clk_sys);
      adc <= '{1'b1, c, s, b};
      @(posedge clk_sys);
      adc <= '{1'b0, ~c, ~s, ~b};
      repeat (3) @(posedge clk_sys);
   endtask : sample

   // Bounded wait; a miss ends the run at once
   task automatic alert_is(input logic e);
      for (int i = 0; i < 8 && alert_n !== e; i++) @(posedge clk_sys);
      check("alert_n", alert_n, e);
      if (alert_n !== e) complete_run();
   endtask : alert_is

   task automatic t_reset();
      @(posedge clk_sys);
      check("setup pins", {range_sel, conv_mode, ch_en}, 8'h7F);
      rchk(8'h20, 32'h00FE);
      rchk(8'h21, 32'h0);
      rchk(8'h28, 32'h0);
      rchk(8'h3F, 32'h0);
   endtask : t_reset

   task automatic t_scale();
      logic [31:0] e;
      sample(2'd0, 16'h4B00, 16'h1D4C);
      rchk(8'h00, 32'h4B00);
      rchk(8'h01, 32'h1D4C);
      rchk(8'h02, 32'h0);
      host.wr(8'h28, 16'h0500);
      sample(2'd0, 16'h4B00, 16'h1D4C);
      rchk(8'h02, 32'h2EE0);
      rchk(8'h03, 32'h1194);
      sample(2'd0, 16'hB500, 16'h1D4C);
      rchk(8'h00, 32'hB500);
      rchk(8'h02, 32'hD120);
      repeat (100) @(posedge clk_sys);
      host.rd(8'h04, e);
      check("energy step", e % 32'h1194, 32'h0);
      check("energy zero", {31'h0, e == 32'h0}, 32'h0);
   endtask : t_scale

   task automatic t_alert();
      host.wr(8'h30, 16'h0001);
      host.wr(8'h38, 16'h7080);
      sample(2'd0, 16'h7081, 16'h0000);
      alert_is(1'b0);
      sample(2'd0, 16'h7080, 16'h0000);
      alert_is(1'b1);
      host.wr(8'h31, 16'h000B);
      host.wr(8'h39, 16'h0010);
      sample(2'd1, 16'h7081, 16'h0010);
      alert_is(1'b1);
      sample(2'd1, 16'h0000, 16'h0011);
      alert_is(1'b0);
      rchk(8'h22, 32'h5);
   endtask : t_alert

   task automatic t_disable();
      dev_en <= 1'b0;
      @(posedge clk_sys);
      host.wr(8'h38, 16'h1234);
      rchk(8'h04, 32'h0);
      rchk(8'h38, 32'h0);
      rchk(8'h30, 32'h0);
      rchk(8'h28, 32'h0500);
      check("alert off", alert_n, 1'b1);
      dev_en <= 1'b1;
      host.wr(8'h20, 16'h00EE);
      @(posedge clk_sys);
      check("chan enables", ch_en, 4'hE);
      sample(2'd0, 16'h1111, 16'h2222);
      rchk(8'h00, 32'h7080);
      ce <= 1'b0;
      repeat (3) @(posedge clk_sys);
      ce <= 1'b1;
   endtask : t_disable

   task automatic t_ready();
      host.wr(8'h21, 16'h0001);
      sample(2'd2, 16'h0000, 16'h0000);
      alert_is(1'b0);
      rchk(8'h22, 32'h1);
   endtask : t_ready

   // Latched trips: power over on slot 2, shunt under on slot 3
   task automatic t_latch();
      host.wr(8'h21, 16'h0002);
      host.wr(8'h2A, 16'h0500);
      host.wr(8'h32, 16'h0015);
      host.wr(8'h3A, 16'h1000);
      host.wr(8'h33, 16'h0012);
      host.wr(8'h3B, 16'hFF00);
      sample(2'd2, 16'h4B00, 16'h1D4C);
      alert_is(1'b0);
      rchk(8'h13, 32'h1194);
      sample(2'd2, 16'hFE00, 16'h1D4C);
      alert_is(1'b0);
      rchk(8'h22, 32'h19);
      alert_is(1'b1);
   endtask : t_latch

   initial begin
      repeat (12) @(posedge clk_sys);
      rstn <= 1'b1;
      t_reset();
      t_scale();
      t_alert();
      t_disable();
      t_ready();
      t_latch();
      complete_run();
   end
endmodule : testbench
